/* tb/bsr_regbank_monitor.sv */
// concurrent checks on the ports of the rail set point register bank
// assumes one clock and synchronous active-high reset; bound below
module bsr_regbank_monitor
    import bsr_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // register bus
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  avs_response,
    // state and rail outputs
    input wire bsr_pstate_t power_state,
    input wire logic [5:0]  ab_normal_code,
    input wire logic [5:0]  ab_standby_code,
    input wire logic [5:0]  ab_sleep_code,
    input wire logic [3:0]  ab_switch_mode_code,
    input wire logic        ab_sleep_behaviour,
    input wire logic        ab_current_limit_sel,
    input wire logic [1:0]  ab_freq_sel,
    input wire logic [1:0]  ab_phase_sel,
    input wire logic [1:0]  ab_scaling_speed_sel,
    input wire logic [5:0]  ab_active_code,
    input wire logic [10:0] ab_active_mv,
    input wire logic        ab_rail_on,
    input wire logic        ab_sleep_pfm,
    input wire logic [3:0]  c_switch_mode_code,
    input wire logic        c_sleep_behaviour,
    input wire logic [5:0]  c_active_code,
    input wire logic [10:0] c_active_mv
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);

    // a write lands on its answer edge, lane 0 enabled
    logic hit;
    assign hit = avs_write && !avs_waitrequest && avs_byteenable[0];

    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in one cycle");
    answer_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    ab_normal_wr_a: assert property (hit && avs_address == 8'h80 |=> ab_normal_code == $past(avs_writedata[5:0]))
        else $error("ab normal code not written");
    ab_mode_wr_a: assert property (hit && avs_address == 8'h8c |=>
        {ab_sleep_behaviour, ab_switch_mode_code} == {$past(avs_writedata[5]), $past(avs_writedata[3:0])})
        else $error("ab mode fields not written");
    ab_cfg_wr_a: assert property (hit && avs_address == 8'h90 |=>
        {ab_scaling_speed_sel, ab_phase_sel, ab_freq_sel, ab_current_limit_sel}
            == {$past(avs_writedata[7:2]), $past(avs_writedata[0])})
        else $error("ab config fields not written");
    c_mode_wr_a: assert property (hit && avs_address == 8'hc4 |=>
        {c_sleep_behaviour, c_switch_mode_code} == {$past(avs_writedata[5]), $past(avs_writedata[3:0])})
        else $error("c mode fields not written");
    mode_hold_a: assert property (!hit |=> $stable(ab_switch_mode_code) && $stable(c_switch_mode_code))
        else $error("mode code moved without a write");
    ab_volt_map_a: assert property (ab_active_mv == 11'h12c + 11'h019 * {5'h00, ab_active_code})
        else $error("ab millivolt target wrong");
    c_volt_map_a: assert property (c_active_mv == 11'h12c + 11'h019 * {5'h00, c_active_code})
        else $error("c millivolt target wrong");
    ab_state_pick_a: assert property (!$past(srst) |-> ab_active_code ==
        ($past(power_state) == BSR_PS_STANDBY ? $past(ab_standby_code) :
         $past(power_state) == BSR_PS_SLEEP ? $past(ab_sleep_code) : $past(ab_normal_code)))
        else $error("ab active code wrong");
    ab_sleep_beh_a: assert property (!$past(srst) |->
        ab_rail_on == !($past(power_state) == BSR_PS_SLEEP && !$past(ab_sleep_behaviour)) &&
        ab_sleep_pfm == ($past(power_state) == BSR_PS_SLEEP && $past(ab_sleep_behaviour)))
        else $error("ab sleep behaviour wrong");
    read_upper_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");

    // main scenarios reached
    cover property (hit);
    cover property (!avs_waitrequest && avs_response == BSR_RESP_DECERR);
    cover property (power_state == BSR_PS_SLEEP && ab_sleep_pfm);
endmodule

bind bsr_regbank bsr_regbank_monitor mon (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .power_state, .ab_normal_code,
    .ab_standby_code, .ab_sleep_code, .ab_switch_mode_code, .ab_sleep_behaviour, .ab_current_limit_sel,
    .ab_freq_sel, .ab_phase_sel, .ab_scaling_speed_sel, .ab_active_code, .ab_active_mv, .ab_rail_on,
    .ab_sleep_pfm, .c_switch_mode_code, .c_sleep_behaviour, .c_active_code, .c_active_mv);

/* tb/testbench.sv */
// self-checking bench for the rail set point register bank
// drives every dut input itself, the registers over avalon-mm and power_state directly; one 10 MHz clock
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import bsr_pkg::*;

    logic        clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, be;
    logic [7:0]  avs_address = 8'h00, d, rd_val, exp_reg [10];
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [3:0]  avs_byteenable = 4'h1, ab_switch_mode_code, c_switch_mode_code;
    logic [1:0]  avs_response, rd_resp, ab_freq_sel, ab_phase_sel, ab_scaling_speed_sel;
    logic [1:0]  c_freq_sel, c_phase_sel, c_scaling_speed_sel;
    logic [5:0]  ab_normal_code, ab_standby_code, ab_sleep_code, ab_active_code;
    logic [5:0]  c_normal_code, c_standby_code, c_sleep_code, c_active_code;
    logic [10:0] ab_active_mv, c_active_mv;
    logic        ab_sleep_behaviour, ab_current_limit_sel, ab_rail_on, ab_sleep_pfm;
    logic        c_sleep_behaviour, c_current_limit_sel, c_rail_on, c_sleep_pfm;
    bsr_pstate_t power_state = BSR_PS_NORMAL;
    integer      n_fail = 0, check_count = 0, seed = 32'h87cd2797, idx;
    localparam logic [7:0] ADR [10] = '{8'h80, 8'h84, 8'h88, 8'h8c, 8'h90, 8'hb8, 8'hbc, 8'hc0, 8'hc4, 8'hc8};
    localparam logic [7:0] MISS [4] = '{8'h94, 8'h81, 8'hcc, 8'h7c};

    always #50 clk = ~clk;

    bsr_regbank dut (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .avs_response, .power_state, .ab_normal_code, .ab_standby_code,
        .ab_sleep_code, .ab_switch_mode_code, .ab_sleep_behaviour, .ab_current_limit_sel, .ab_freq_sel,
        .ab_phase_sel, .ab_scaling_speed_sel, .ab_active_code, .ab_active_mv, .ab_rail_on, .ab_sleep_pfm,
        .c_normal_code, .c_standby_code, .c_sleep_code, .c_switch_mode_code, .c_sleep_behaviour,
        .c_current_limit_sel, .c_freq_sel, .c_phase_sel, .c_scaling_speed_sel, .c_active_code, .c_active_mv,
        .c_rail_on, .c_sleep_pfm);

    // writable bits per register
    function automatic logic [7:0] wmask(int i);
        return (i % 5 < 3) ? 8'h3f : (i % 5 == 3) ? 8'h2f : 8'hff;
    endfunction

    // set point for the present state
    function automatic logic [5:0] pick(int r);
        if (power_state == BSR_PS_STANDBY) return exp_reg[r * 5 + 1][5:0];
        if (power_state == BSR_PS_SLEEP) return exp_reg[r * 5 + 2][5:0];
        return exp_reg[r * 5][5:0];
    endfunction

    function automatic logic [18:0] target(int r);
        logic s;
        s = power_state == BSR_PS_SLEEP;
        return {pick(r), 11'h12c + 11'h019 * {5'h00, pick(r)}, !(s && !exp_reg[r * 5 + 3][5]), s && exp_reg[r * 5 + 3][5]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
            n_fail++;
        end
    endtask

    // one transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] dat, input logic en);
        avs_address <= a;
        avs_writedata <= {24'h000000, dat};
        avs_byteenable <= {3'h0, en};
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd_val = avs_readdata[7:0];
        rd_resp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    // read all ten rail registers (not status), then the field ports
    task automatic check_all;
        for (int i = 0; i < 10; i++) begin
            bus(1'b0, ADR[i], 8'h00, 1'b1);
            chk({rd_resp, rd_val}, {BSR_RESP_OKAY, exp_reg[i]});
        end
        chk(32'({ab_normal_code, ab_standby_code, ab_sleep_code, ab_sleep_behaviour, ab_switch_mode_code}),
            32'({exp_reg[0][5:0], exp_reg[1][5:0], exp_reg[2][5:0], exp_reg[3][5], exp_reg[3][3:0]}));
        chk(32'({c_normal_code, c_standby_code, c_sleep_code, c_sleep_behaviour, c_switch_mode_code}),
            32'({exp_reg[5][5:0], exp_reg[6][5:0], exp_reg[7][5:0], exp_reg[8][5], exp_reg[8][3:0]}));
        chk(32'({ab_scaling_speed_sel, ab_phase_sel, ab_freq_sel, ab_current_limit_sel,
            c_scaling_speed_sel, c_phase_sel, c_freq_sel, c_current_limit_sel}),
            32'({exp_reg[4][7:2], exp_reg[4][0], exp_reg[9][7:2], exp_reg[9][0]}));
        chk(32'({ab_active_code, ab_active_mv, ab_rail_on, ab_sleep_pfm}), 32'(target(0)));
        chk(32'({c_active_code, c_active_mv, c_rail_on, c_sleep_pfm}), 32'(target(1)));
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // watchdog: the run needs about seven hundred cycles
    initial begin
        #2000000;
        n_fail++;
        complete_run;
    end

    initial begin
        for (int i = 0; i < 10; i++) exp_reg[i] = (i % 5 == 3) ? 8'h08 : 8'h00;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check_all;
        // misses answer with a decode error
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, MISS[i], 8'hff, 1'b1);
            chk(32'(rd_resp), 32'(BSR_RESP_DECERR));
            bus(1'b0, MISS[i], 8'h00, 1'b1);
            chk({rd_resp, rd_val}, {BSR_RESP_DECERR, 8'h00});
        end
        // all ones shows which bits store
        for (int i = 0; i < 10; i++) begin
            bus(1'b1, ADR[i], 8'hff, 1'b1);
            exp_reg[i] = wmask(i);
        end
        check_all;
        // random writes, lane 0 sometimes off, state moving
        for (int k = 0; k < 80; k++) begin
            idx = {$random(seed)} % 10;
            d = 8'($random(seed));
            be = ($random(seed) & 7) != 0;
            bus(1'b1, ADR[idx], d, be);
            if (be) exp_reg[idx] = d & wmask(idx);
            power_state <= bsr_pstate_t'(2'($random(seed)));
            if (k % 8 == 7) check_all;
        end
        // sleep with pfm on one rail and off on the other
        bus(1'b1, 8'h8c, 8'h20, 1'b1);
        bus(1'b1, 8'hc4, 8'h07, 1'b1);
        exp_reg[3] = 8'h20;
        exp_reg[8] = 8'h07;
        power_state <= BSR_PS_SLEEP;
        check_all;
        // reset in mid-run brings every field back
        srst <= 1'b1;
        power_state <= BSR_PS_NORMAL;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 10; i++) exp_reg[i] = (i % 5 == 3) ? 8'h08 : 8'h00;
        @(posedge clk);
        check_all;
        complete_run;
    end
endmodule

/* verilog/bsr_pkg.sv */
// package for the step-down rail set point register bank
// assumes one 10 MHz clock and a synchronous active-high reset everywhere

package bsr_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [5:0] BSR_IDX_AB_NORMAL  = 6'h20;
    localparam logic [5:0] BSR_IDX_AB_STANDBY = 6'h21;
    localparam logic [5:0] BSR_IDX_AB_SLEEP   = 6'h22;
    localparam logic [5:0] BSR_IDX_AB_MODE    = 6'h23;
    localparam logic [5:0] BSR_IDX_AB_CONFIG  = 6'h24;
    localparam logic [5:0] BSR_IDX_C_NORMAL   = 6'h2e;
    localparam logic [5:0] BSR_IDX_C_STANDBY  = 6'h2f;
    localparam logic [5:0] BSR_IDX_C_SLEEP    = 6'h30;
    localparam logic [5:0] BSR_IDX_C_MODE     = 6'h31;
    localparam logic [5:0] BSR_IDX_C_CONFIG   = 6'h32;
    localparam logic [5:0] BSR_IDX_STATUS     = 6'h34;

    // one register set per output, five registers each
    localparam int                BSR_NUM_RAILS = 2;
    localparam logic [2:0]        BSR_RAIL_REGS = 3'h5;
    localparam logic [1:0][5:0]   BSR_RAIL_BASE = {BSR_IDX_C_NORMAL, BSR_IDX_AB_NORMAL};

    // register position inside one rail set
    localparam logic [2:0] BSR_LOC_NORMAL  = 3'h0;
    localparam logic [2:0] BSR_LOC_STANDBY = 3'h1;
    localparam logic [2:0] BSR_LOC_SLEEP   = 3'h2;
    localparam logic [2:0] BSR_LOC_MODE    = 3'h3;
    localparam logic [2:0] BSR_LOC_CONFIG  = 3'h4;

    // field positions
    localparam int BSR_CODE_MSB      = 5;
    localparam int BSR_MODE_MSB      = 3;
    localparam int BSR_SLEEP_BEH_BIT = 5;
    localparam int BSR_ILIM_BIT      = 0;
    localparam int BSR_FREQ_LSB      = 2;
    localparam int BSR_PHASE_LSB     = 4;
    localparam int BSR_SPEED_LSB     = 6;

    // values after reset
    localparam logic [5:0] BSR_CODE_RST = 6'h00;
    localparam logic [3:0] BSR_MODE_RST = 4'h8;
    localparam logic       BSR_BEH_RST  = 1'b0;
    localparam logic [7:0] BSR_CFG_RST  = 8'h00;

    // set point code to millivolts: base plus code times step
    localparam logic [10:0] BSR_VBASE_MV = 11'h12c;
    localparam logic [10:0] BSR_VSTEP_MV = 11'h019;

    // avalon response codes
    localparam logic [1:0] BSR_RESP_OKAY   = 2'h0;
    localparam logic [1:0] BSR_RESP_DECERR = 2'h3;

    // operating state of the regulators, driven by the power sequencer
    typedef enum logic [1:0] {
        BSR_PS_NORMAL,
        BSR_PS_STANDBY,
        BSR_PS_SLEEP
    } bsr_pstate_t;

    // bus slave sequencing
    typedef enum logic {
        BSR_BUS_IDLE,
        BSR_BUS_ANSWER
    } bsr_bus_state_t;

endpackage

/* verilog/bsr_rail_regs.sv */
// one rail's register set: three set points, mode selector, configuration
// assumes the bus slave gives a one-cycle write strobe with a local index

module bsr_rail_regs (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // register access
    input  wire logic       wr_stb,
    input  wire logic [2:0] wr_loc,
    input  wire logic [7:0] wr_data,
    input  wire logic [2:0] rd_loc,
    output logic      [7:0] rd_data,
    // stored fields
    output logic      [5:0] normal_code_reg,
    output logic      [5:0] standby_code_reg,
    output logic      [5:0] sleep_code_reg,
    output logic      [3:0] switch_mode_code_reg,
    output logic            sleep_behaviour_reg,
    output logic      [7:0] config_reg
);
    import bsr_pkg::*;

    // set points; only the six code bits are kept
    always_ff @(posedge clk) begin
        if (srst) begin
            normal_code_reg  <= BSR_CODE_RST;
            standby_code_reg <= BSR_CODE_RST;
            sleep_code_reg   <= BSR_CODE_RST;
        end else if (wr_stb) begin
            if (wr_loc == BSR_LOC_NORMAL)  normal_code_reg  <= wr_data[BSR_CODE_MSB:0];
            if (wr_loc == BSR_LOC_STANDBY) standby_code_reg <= wr_data[BSR_CODE_MSB:0];
            if (wr_loc == BSR_LOC_SLEEP)   sleep_code_reg   <= wr_data[BSR_CODE_MSB:0];
        end
    end

    // mode selector; bits 4, 6 and 7 have no storage
    always_ff @(posedge clk) begin
        if (srst) begin
            switch_mode_code_reg <= BSR_MODE_RST;
            sleep_behaviour_reg  <= BSR_BEH_RST;
        end else if (wr_stb && wr_loc == BSR_LOC_MODE) begin
            switch_mode_code_reg <= wr_data[BSR_MODE_MSB:0];
            sleep_behaviour_reg  <= wr_data[BSR_SLEEP_BEH_BIT];
        end
    end

    // configuration is a full byte; the spare bit 1 also reads back
    always_ff @(posedge clk) begin
        if (srst) begin
            config_reg <= BSR_CFG_RST;
        end else if (wr_stb && wr_loc == BSR_LOC_CONFIG) begin
            config_reg <= wr_data;
        end
    end

    // read mux; unused bits return zero
    always_comb begin
        case (rd_loc)
            BSR_LOC_NORMAL:  rd_data = {2'h0, normal_code_reg};
            BSR_LOC_STANDBY: rd_data = {2'h0, standby_code_reg};
            BSR_LOC_SLEEP:   rd_data = {2'h0, sleep_code_reg};
            BSR_LOC_MODE:    rd_data = {2'h0, sleep_behaviour_reg, 1'b0, switch_mode_code_reg};
            BSR_LOC_CONFIG:  rd_data = config_reg;
            default:         rd_data = 8'h00;
        endcase
    end

endmodule

/* verilog/bsr_regbank.sv */
// top of the step-down rail set point register bank with its avalon-mm slave
// assumes a single 10 MHz clock, synchronous reset and a sequencer on the same clock

module bsr_regbank (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 srst,
    // avalon-mm slave, byte addressed, one word per register
    input  wire logic          [7:0]  avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic         [31:0]  avs_writedata,
    input  wire logic          [3:0]  avs_byteenable,
    output logic              [31:0]  avs_readdata,
    output logic                      avs_waitrequest,
    output logic               [1:0]  avs_response,
    // operating state from the power sequencer
    input  wire bsr_pkg::bsr_pstate_t power_state,
    // a/b rail settings
    output logic               [5:0]  ab_normal_code,
    output logic               [5:0]  ab_standby_code,
    output logic               [5:0]  ab_sleep_code,
    output logic               [3:0]  ab_switch_mode_code,
    output logic                      ab_sleep_behaviour,
    output logic                      ab_current_limit_sel,
    output logic               [1:0]  ab_freq_sel,
    output logic               [1:0]  ab_phase_sel,
    output logic               [1:0]  ab_scaling_speed_sel,
    // a/b rail targets for the present state
    output logic               [5:0]  ab_active_code,
    output logic              [10:0]  ab_active_mv,
    output logic                      ab_rail_on,
    output logic                      ab_sleep_pfm,
    // c rail settings
    output logic               [5:0]  c_normal_code,
    output logic               [5:0]  c_standby_code,
    output logic               [5:0]  c_sleep_code,
    output logic               [3:0]  c_switch_mode_code,
    output logic                      c_sleep_behaviour,
    output logic                      c_current_limit_sel,
    output logic               [1:0]  c_freq_sel,
    output logic               [1:0]  c_phase_sel,
    output logic               [1:0]  c_scaling_speed_sel,
    // c rail targets for the present state
    output logic               [5:0]  c_active_code,
    output logic              [10:0]  c_active_mv,
    output logic                      c_rail_on,
    output logic                      c_sleep_pfm
);
    import bsr_pkg::*;

    // per-rail views, element 0 is a/b and element 1 is c
    logic [5:0]  normal_code      [BSR_NUM_RAILS];
    logic [5:0]  standby_code     [BSR_NUM_RAILS];
    logic [5:0]  sleep_code       [BSR_NUM_RAILS];
    logic [3:0]  switch_mode_code [BSR_NUM_RAILS];
    logic        sleep_behaviour  [BSR_NUM_RAILS];
    logic [7:0]  config_byte      [BSR_NUM_RAILS];
    logic [5:0]  active_code      [BSR_NUM_RAILS];
    logic [10:0] active_mv        [BSR_NUM_RAILS];
    logic        rail_on          [BSR_NUM_RAILS];
    logic        sleep_pfm        [BSR_NUM_RAILS];
    logic [7:0]  rail_rd_data     [BSR_NUM_RAILS];
    logic        rail_hit         [BSR_NUM_RAILS];
    logic [2:0]  rail_loc         [BSR_NUM_RAILS];
    logic        rail_wr_stb      [BSR_NUM_RAILS];

    // bus slave state
    bsr_bus_state_t bus_state_reg;
    logic [31:0]    readdata_reg;
    logic           waitrequest_reg;
    logic [1:0]     response_reg;

    // address decode
    logic [5:0]     reg_index;
    logic           word_aligned;
    logic           status_hit;
    logic           any_hit;
    logic           bus_req;
    logic           write_commit;
    logic [7:0]     rd_byte;
    logic [7:0]     status_byte;

    // the register index is the byte address divided by four
    assign reg_index    = avs_address[7:2];
    assign word_aligned = (avs_address[1:0] == 2'h0);
    assign status_hit   = word_aligned && (reg_index == BSR_IDX_STATUS);
    assign bus_req      = avs_read || avs_write;

    // a write lands only at the edge where waitrequest is seen low
    assign write_commit = (bus_state_reg == BSR_BUS_ANSWER) && avs_write && avs_byteenable[0];

    // one register set and one target converter per rail
    genvar g;
    generate
        for (g = 0; g < BSR_NUM_RAILS; g++) begin : g_rail
            // each rail owns five consecutive indices from its base
            assign rail_loc[g]    = 3'(reg_index - BSR_RAIL_BASE[g]);
            assign rail_hit[g]    = word_aligned && (reg_index >= BSR_RAIL_BASE[g])
                                    && (reg_index < BSR_RAIL_BASE[g] + 6'(BSR_RAIL_REGS));
            assign rail_wr_stb[g] = write_commit && rail_hit[g];

            bsr_rail_regs u_regs (
                .clk                  (clk),
                .srst                 (srst),
                .wr_stb               (rail_wr_stb[g]),
                .wr_loc               (rail_loc[g]),
                .wr_data              (avs_writedata[7:0]),
                .rd_loc               (rail_loc[g]),
                .rd_data              (rail_rd_data[g]),
                .normal_code_reg      (normal_code[g]),
                .standby_code_reg     (standby_code[g]),
                .sleep_code_reg       (sleep_code[g]),
                .switch_mode_code_reg (switch_mode_code[g]),
                .sleep_behaviour_reg  (sleep_behaviour[g]),
                .config_reg           (config_byte[g])
            );

            bsr_setpoint_conv u_conv (
                .clk             (clk),
                .srst            (srst),
                .power_state     (power_state),
                .normal_code     (normal_code[g]),
                .standby_code    (standby_code[g]),
                .sleep_code      (sleep_code[g]),
                .sleep_behaviour (sleep_behaviour[g]),
                .active_code_reg (active_code[g]),
                .active_mv_reg   (active_mv[g]),
                .rail_on_reg     (rail_on[g]),
                .sleep_pfm_reg   (sleep_pfm[g])
            );
        end
    endgenerate

    assign any_hit = rail_hit[0] || rail_hit[1] || status_hit;

    // status byte: present state and the on/pfm view of both rails
    assign status_byte = {2'h0, sleep_pfm[1], rail_on[1], sleep_pfm[0], rail_on[0], power_state};

    // read data for the addressed register; misses read zero
    always_comb begin
        if (rail_hit[0]) begin
            rd_byte = rail_rd_data[0];
        end else if (rail_hit[1]) begin
            rd_byte = rail_rd_data[1];
        end else if (status_hit) begin
            rd_byte = status_byte;
        end else begin
            rd_byte = 8'h00;
        end
    end

    // two-step handshake: the request is seen in idle, answered one cycle later.
    // the answer always takes exactly one wait cycle, which keeps the read mux
    // off the path from the bus inputs to the outputs at no real cost.
    always_ff @(posedge clk) begin
        if (srst) begin
            bus_state_reg   <= BSR_BUS_IDLE;
            waitrequest_reg <= 1'b1;
        end else begin
            case (bus_state_reg)
                BSR_BUS_IDLE: begin
                    if (bus_req) begin
                        bus_state_reg   <= BSR_BUS_ANSWER;
                        waitrequest_reg <= 1'b0;
                    end
                end
                BSR_BUS_ANSWER: begin
                    bus_state_reg   <= BSR_BUS_IDLE;
                    waitrequest_reg <= 1'b1;
                end
                default: begin
                    bus_state_reg   <= BSR_BUS_IDLE;
                    waitrequest_reg <= 1'b1;
                end
            endcase
        end
    end

    // read data and response are captured when the request is first seen;
    // the master holds the address, so they stay valid through the answer
    always_ff @(posedge clk) begin
        if (srst) begin
            readdata_reg <= 32'h0000_0000;
            response_reg <= BSR_RESP_OKAY;
        end else if (bus_state_reg == BSR_BUS_IDLE && bus_req) begin
            readdata_reg <= avs_read ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            response_reg <= any_hit ? BSR_RESP_OKAY : BSR_RESP_DECERR;
        end
    end

    assign avs_readdata    = readdata_reg;
    assign avs_waitrequest = waitrequest_reg;
    assign avs_response    = response_reg;

    // a/b settings straight from the register flops
    assign ab_normal_code       = normal_code[0];
    assign ab_standby_code      = standby_code[0];
    assign ab_sleep_code        = sleep_code[0];
    assign ab_switch_mode_code  = switch_mode_code[0];
    assign ab_sleep_behaviour   = sleep_behaviour[0];
    assign ab_current_limit_sel = config_byte[0][BSR_ILIM_BIT];
    assign ab_freq_sel          = config_byte[0][BSR_FREQ_LSB +: 2];
    assign ab_phase_sel         = config_byte[0][BSR_PHASE_LSB +: 2];
    assign ab_scaling_speed_sel = config_byte[0][BSR_SPEED_LSB +: 2];

    // a/b targets from the converter flops
    assign ab_active_code = active_code[0];
    assign ab_active_mv   = active_mv[0];
    assign ab_rail_on     = rail_on[0];
    assign ab_sleep_pfm   = sleep_pfm[0];

    // c settings use the same byte layout but their own storage
    assign c_normal_code       = normal_code[1];
    assign c_standby_code      = standby_code[1];
    assign c_sleep_code        = sleep_code[1];
    assign c_switch_mode_code  = switch_mode_code[1];
    assign c_sleep_behaviour   = sleep_behaviour[1];
    assign c_current_limit_sel = config_byte[1][BSR_ILIM_BIT];
    assign c_freq_sel          = config_byte[1][BSR_FREQ_LSB +: 2];
    assign c_phase_sel         = config_byte[1][BSR_PHASE_LSB +: 2];
    assign c_scaling_speed_sel = config_byte[1][BSR_SPEED_LSB +: 2];

    // c targets from the converter flops
    assign c_active_code = active_code[1];
    assign c_active_mv   = active_mv[1];
    assign c_rail_on     = rail_on[1];
    assign c_sleep_pfm   = sleep_pfm[1];

endmodule

/* verilog/bsr_setpoint_conv.sv */
// picks the set point for the present operating state and scales it to millivolts
// assumes the operating state is synchronous to clk

module bsr_setpoint_conv (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                srst,
    // state and stored set points
    input  wire bsr_pkg::bsr_pstate_t power_state,
    input  wire logic         [5:0]  normal_code,
    input  wire logic         [5:0]  standby_code,
    input  wire logic         [5:0]  sleep_code,
    input  wire logic                sleep_behaviour,
    // regulator targets
    output logic              [5:0]  active_code_reg,
    output logic             [10:0]  active_mv_reg,
    output logic                     rail_on_reg,
    output logic                     sleep_pfm_reg
);
    import bsr_pkg::*;

    logic [5:0] code_next;

    // choose the code for the present state
    always_comb begin
        case (power_state)
            BSR_PS_STANDBY: code_next = standby_code;
            BSR_PS_SLEEP:   code_next = sleep_code;
            default:        code_next = normal_code;
        endcase
    end

    // linear map, 63 * 25 + 300 = 1875 fits in eleven bits
    always_ff @(posedge clk) begin
        if (srst) begin
            active_code_reg <= BSR_CODE_RST;
            active_mv_reg   <= BSR_VBASE_MV;
        end else begin
            active_code_reg <= code_next;
            active_mv_reg   <= BSR_VBASE_MV + 11'({5'h00, code_next} * BSR_VSTEP_MV);
        end
    end

    // in sleep the rail is either off or held in pulse-frequency mode
    always_ff @(posedge clk) begin
        if (srst) begin
            rail_on_reg   <= 1'b1;
            sleep_pfm_reg <= 1'b0;
        end else begin
            rail_on_reg   <= !(power_state == BSR_PS_SLEEP && !sleep_behaviour);
            sleep_pfm_reg <= (power_state == BSR_PS_SLEEP) && sleep_behaviour;
        end
    end

endmodule
